// ===== hw/iox_pkg.sv
// Constants, register map and state encoding of the I/O expander.
package iox_pkg;
  // System clock and serial input filter timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILT_NS = 16;
  localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycles after a reset before the stored input is trusted: synchroniser,
  // filter, pin driver register and two spare cycles.
  localparam int SETTLE_CYC = 2 + FILT_CYC + 3;
  // Highest serial clock rate served (fast mode).
  localparam int FAST_MODE_KHZ = 400;
  // Serial bus framing.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] DEV_ADDR_HI = 4'h4;
  // Register pointer codes sent after the address byte.
  localparam logic [1:0] PTR_INPUT = 2'h0;
  localparam logic [1:0] PTR_OUTPUT = 2'h1;
  localparam logic [1:0] PTR_POLARITY = 2'h2;
  localparam logic [1:0] PTR_DIRECTION = 2'h3;
  // Port register reset values; a direction bit of one means input.
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  // Reset levels of the filtered inputs: serial lines idle high.
  localparam logic [12:0] PIN_RST = 13'h1800;
  // APB register byte offsets.
  localparam int APB_AW = 8;
  localparam logic [7:0] OFF_IRQ_STS = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFF_PORT_STATE = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  // Interrupt status bits and control bits.
  localparam int IRQ_W = 2;
  localparam int IRQ_IN_CHANGE = 0;
  localparam int IRQ_WR_DONE = 1;
  localparam int CTRL_SRST_BIT = 0;
  // Serial target states.
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_PTR   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } iox_state_t;
endpackage

// ===== hw/iox_sync_filt.sv
// Two-flop synchroniser followed by a per-bit glitch filter.
`timescale 1ns/100ps
`default_nettype none
module iox_sync_filt #(
  parameter int WIDTH = 1,
  parameter int FILT = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  localparam int CW = $clog2(FILT + 1);

  generate
    if (FILT < 1 || WIDTH < 1) begin : g_bad
      $error("iox_sync_filt needs WIDTH and FILT of at least one");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      logic q_r;
      logic [CW-1:0] cnt_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= RST_VAL[i];
          sync_r <= RST_VAL[i];
        end else begin
          meta_r <= d_i[i];
          sync_r <= meta_r;
        end
      end
      // A new level is taken only after it stood for FILT cycles.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q_r <= RST_VAL[i];
          cnt_r <= '0;
        end else if (sync_r == q_r) begin
          cnt_r <= '0;
        end else if (cnt_r == CW'(FILT - 1)) begin
          q_r <= sync_r;
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
      assign q_o[i] = q_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== hw/iox_expander.sv
// Eight-bit serial-bus I/O expander with an APB interrupt and control side.
//
// What this block does
// (RL1) Four byte registers: direction, input, output, polarity.
// (RL2) Reset leaves all eight pins as inputs.
// (RL3) Master sets pin direction through direction register.
// (RL4) Input register senses pins; output register drives.
// (RL5) Polarity bit inverts the sensed input value.
// (RL6) Every register can be read back serially.
// (RL7) Reset restores defaults and the serial state machine.
// (RL8) Interrupt while any input differs from stored.
// (RL9) Interrupt is open-drain and active low.
// (RL10) Three select pins set low address bits.
// (RL11) Serial target serves fast-mode clock rates.
// (RL12) Outputs hold their level until rewritten or reset.
// (RL13) Serial clock and data are noise filtered.
// (RL14) Interrupt line needs no bus transaction.
// (RL15) Pointer byte after address picks the register.
// (RL16) Reading input register resyncs and clears interrupt.
`timescale 1ns/100ps
`default_nettype none
module iox_expander
  import iox_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [iox_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Serial target lines, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Open-drain active-low interrupt
  output logic int_n_o,
  output logic int_oe,
  // Address select straps
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2,
  // Port pins
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe
);
  import iox_pkg::*;

  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  // Filtered inputs.
  logic [12:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic [2:0] addr_f;
  logic [7:0] port_f;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ev_ok;
  // Serial engine.
  iox_state_t st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic ack_ok_r;
  logic sda_oe_r;
  logic [6:0] dev_addr;
  logic ptr_load;
  logic wr_commit;
  logic rd_load;
  logic rd_in_cap;
  logic [7:0] rd_byte;
  // Port registers.
  logic [1:0] ptr_r;
  logic [7:0] dir_r;
  logic [7:0] out_r;
  logic [7:0] pol_r;
  logic [7:0] in_reg_r;
  logic init_r;
  logic [SETTLE_W-1:0] settle_r;
  logic [7:0] in_now;
  logic int_pend;
  logic int_oe_r;
  logic [7:0] port_out_r;
  logic [7:0] port_oe_r;
  // APB side.
  logic [IRQ_W-1:0] sts_r;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] clr;
  logic irq_r;
  logic soft_rst_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic apb_wr;
  logic apb_acc;
  logic [31:0] rd_word;
  logic rd_hit;

  // The SCL and SDA filter rejects spikes shorter than FILT_CYC cycles,
  // so the serial clock must stay high and low for a few pclk periods.
  iox_sync_filt #(
    .WIDTH(13),
    .FILT(FILT_CYC),
    .RST_VAL(PIN_RST)
  ) u_filt (
    .clk(pclk),
    .rst_n(presetn),
    .d_i({scl_i, sda_i, addr_sel_bit2, addr_sel_bit1, addr_sel_bit0,
          port_pin_i}),
    .q_o(pins_f)
  ); // RL13

  assign scl_f = pins_f[12];
  assign sda_f = pins_f[11];
  assign addr_f = pins_f[10:8];
  assign port_f = pins_f[7:0];
  assign dev_addr = {DEV_ADDR_HI, addr_f}; // RL10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_det = scl_f & scl_d_r & ~sda_d_r & sda_f;
  assign ev_ok = ~soft_rst_r & ~stop_det & ~start_det;
  assign ptr_load = ev_ok & scl_fall & (st_r == ST_PTR) &
                    (bit_cnt_r == BYTE_BITS); // RL15
  assign wr_commit = ev_ok & scl_fall & (st_r == ST_WDATA) &
                     (bit_cnt_r == BYTE_BITS);
  assign rd_load = ev_ok & scl_fall & (((st_r == ST_AACK) & rw_r) |
                   ((st_r == ST_RACK) & ack_ok_r));
  assign rd_in_cap = rd_load & (ptr_r == PTR_INPUT); // RL16

  // Read-back of the addressed register.
  always_comb begin
    case (ptr_r)
      PTR_INPUT: rd_byte = in_now; // RL4
      PTR_OUTPUT: rd_byte = out_r;
      PTR_POLARITY: rd_byte = pol_r;
      default: rd_byte = dir_r;
    endcase
  end // RL6

  // Serial target engine; the engine runs on pclk and only samples SCL
  // edges, which keeps it usable up to fast-mode rates. RL11
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      ack_ok_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (soft_rst_r || stop_det) begin
      st_r <= ST_IDLE; // RL7
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      st_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BYTE_BITS) begin
            bit_cnt_r <= 4'h0;
            if (st_r == ST_ADDR) begin
              if (shift_r[7:1] == dev_addr) begin // RL10
                st_r <= ST_AACK;
                sda_oe_r <= 1'b1;
                rw_r <= shift_r[0];
              end else begin
                st_r <= ST_IDLE;
              end
            end else if (st_r == ST_PTR) begin
              st_r <= ST_PACK;
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= ST_WACK;
              sda_oe_r <= 1'b1;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              st_r <= ST_RDATA;
              shift_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              st_r <= ST_PTR;
              sda_oe_r <= 1'b0;
            end
          end
        end
        ST_PACK, ST_WACK: begin
          if (scl_fall) begin
            st_r <= ST_WDATA;
            sda_oe_r <= 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == BYTE_BITS - 4'h1) begin
              st_r <= ST_RACK;
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 4'h0;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_r <= ~shift_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_ok_r <= ~sda_f;
          end else if (scl_fall) begin
            if (ack_ok_r) begin
              st_r <= ST_RDATA;
              shift_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Pointer and writable port registers; the input register is read only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= PTR_INPUT;
      dir_r <= DIR_RST; // RL2
      out_r <= OUT_RST;
      pol_r <= POL_RST;
    end else if (soft_rst_r) begin
      ptr_r <= PTR_INPUT; // RL7
      dir_r <= DIR_RST;
      out_r <= OUT_RST;
      pol_r <= POL_RST;
    end else if (ptr_load) begin
      ptr_r <= shift_r[1:0]; // RL15
    end else if (wr_commit) begin
      case (ptr_r)
        PTR_OUTPUT: out_r <= shift_r; // RL12
        PTR_POLARITY: pol_r <= shift_r;
        PTR_DIRECTION: dir_r <= shift_r; // RL3
        default: begin
        end
      endcase
    end
  end // RL1

  assign in_now = port_f ^ pol_r; // RL5
  assign int_pend = init_r & (|((in_now ^ in_reg_r) & dir_r)); // RL8

  // The stored input follows the pins until the filters have settled after
  // a reset; priming it at once would latch the filter reset level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reg_r <= 8'h00;
      settle_r <= '0;
      init_r <= 1'b0;
    end else if (soft_rst_r) begin
      settle_r <= '0;
      init_r <= 1'b0;
    end else if (!init_r) begin
      in_reg_r <= in_now;
      settle_r <= settle_r + SETTLE_W'(1);
      init_r <= (settle_r == SETTLE_W'(SETTLE_CYC - 1));
    end else if (rd_in_cap) begin
      in_reg_r <= in_now; // RL16
    end
  end

  // Pin drivers and open-drain outputs; the open-drain driven level is always low, the pins drive out_r.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out_r <= OUT_RST;
      port_oe_r <= 8'h00;
      int_oe_r <= 1'b0;
    end else begin
      port_out_r <= out_r; // RL4
      port_oe_r <= ~dir_r; // RL2
      int_oe_r <= int_pend; // RL14
    end
  end

  // APB access: pready comes one cycle into the access phase.
  assign apb_acc = psel & penable & pready_r;
  assign apb_wr = apb_acc & pwrite;
  assign evt[IRQ_IN_CHANGE] = int_pend & ~int_oe_r;
  assign evt[IRQ_WR_DONE] = wr_commit;
  assign clr = (apb_wr && paddr == OFF_IRQ_STS) ? pwdata[IRQ_W-1:0] :
               {IRQ_W{1'b0}};

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFF_IRQ_STS: rd_word[IRQ_W-1:0] = sts_r;
      OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = mask_r;
      OFF_PORT_STATE: rd_word = {pol_r, dir_r, out_r, in_reg_r};
      OFF_CTRL: rd_word = 32'h0000_0000;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      if (psel && penable && !pready_r) begin
        pslverr_r <= ~rd_hit;
        prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= {IRQ_W{1'b0}};
      mask_r <= {IRQ_W{1'b0}};
      irq_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~clr) | evt;
      if (apb_wr && paddr == OFF_IRQ_MASK) begin
        mask_r <= pwdata[IRQ_W-1:0];
      end
      irq_r <= |(sts_r & mask_r);
      soft_rst_r <= apb_wr & (paddr == OFF_CTRL) & pwdata[CTRL_SRST_BIT];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign int_n_o = 1'b0; // RL9
  assign int_oe = int_oe_r;
  assign port_pin_o = port_out_r;
  assign port_pin_oe = port_oe_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_apb_access;
    psel && penable && !pready_r;
  endsequence

  chk_dir_default: assert property (soft_rst_r |=> dir_r == DIR_RST ##1 port_oe_r == 8'h00) else $error("pins not inputs after reset"); // RL2
  chk_int_follow: assert property (int_pend != int_oe_r |=> int_oe == $past(int_pend)) else $error("interrupt does not follow mismatch"); // RL8
  chk_read_resync: assert property (rd_in_cap && !soft_rst_r |=> in_reg_r == $past(in_now) && !int_pend || $changed(port_f)) else $error("input read did not resync"); // RL16
  chk_out_latched: assert property (!wr_commit && !soft_rst_r |=> $stable(out_r)) else $error("output changed without write"); // RL12
  chk_ack_drive: assert property ((st_r == ST_PACK || st_r == ST_WACK) |-> sda_oe) else $error("no ack driven"); // RL15
  chk_stop_idle: assert property (stop_det |=> st_r == ST_IDLE && !sda_oe) else $error("stop not honoured"); // RL7
  chk_addr_miss: assert property (ev_ok && scl_fall && st_r == ST_ADDR && bit_cnt_r == BYTE_BITS && shift_r[7:1] != dev_addr |=> st_r == ST_IDLE) else $error("foreign address acked"); // RL10
  chk_pin_drive: assert property (wr_commit && ptr_r == PTR_OUTPUT |=> ##1 port_pin_o == $past(shift_r, 2)) else $error("output pins not driven"); // RL4
  chk_irq_level: assert property ((sts_r & mask_r) != 0 |=> irq) else $error("masked status lost"); // RL14
  chk_apb_answer: assert property (s_apb_setup ##1 s_apb_access |=> pready ##1 !pready) else $error("apb answer late"); // RL6
endmodule
`default_nettype wire

// ===== sim/iox_i2c_master.sv
// Behavioural serial bus master that drives the expander's target port.
`timescale 1ns/100ps
`default_nettype none
module iox_i2c_master (
  // Wired data line level
  input wire logic sda,
  // Open-drain pulls, high while this master holds the line low
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // One clock pulse, 40 ns low and 24 ns high; data is sampled late in the
  // high phase because the target's reply lags the clock edge it answers.
  task automatic clk_bit(output logic s);
    begin
      #24 scl_low = 1'b0;
      #24 s = sda;
      scl_low = 1'b1;
      #16;
    end
  endtask
  // The 3 ns offset moves the line changes off the pclk edge the call began on; each further start adds another 3 ns.
  task automatic start;
    begin
      #3 sda_low = 1'b1;
      #32 scl_low = 1'b1;
      #16;
    end
  endtask
  task automatic stop;
    begin
      sda_low = 1'b1;
      #24 scl_low = 1'b0;
      #24 sda_low = 1'b0;
      #64;
    end
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    begin
      for (int i = 7; i >= 0; i--) begin
        sda_low = ~b[i];
        clk_bit(s);
      end
      sda_low = 1'b0;
      clk_bit(s);
      ack = ~s;
    end
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    begin
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--) begin
        clk_bit(s);
        b[i] = s;
      end
      sda_low = ~last;
      clk_bit(s);
    end
  endtask
  // Pointer byte first, then the data byte for that register.
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    begin
      start();
      put({a, 1'b0}, k0);
      put(p, k1);
      put(d, k2);
      stop();
      ok = k0 & k1 & k2;
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    begin
      start();
      put({a, 1'b0}, k0);
      put(p, k1);
      stop();
      start();
      put({a, 1'b1}, k2);
      get(1'b1, d);
      stop();
      ok = k0 & k1 & k2;
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/iox_expander_test.sv
// Self-checking bench of the I/O expander with a serial master model.
`timescale 1ns/100ps
`default_nettype none
module iox_expander_test;
  import iox_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, ext, pin, po, poe, d, o, p, g;
  logic [31:0] pwdata, prdata, rd;
  logic sda_o, sda_oe, int_n_o, int_oe, scl_low, m_low, sda_w, er, ok;
  logic [2:0] asel;
  logic [6:0] dev;
  logic [7:0] exp_r [4];
  int bad_count, samples_checked;
  // Driven pins read back their own level; the others follow the bench.
  assign pin = (poe & po) | (~poe & ext);
  assign sda_w = ~((sda_oe & ~sda_o) | m_low);
  iox_expander dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl_i(~scl_low), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .int_n_o(int_n_o), .int_oe(int_oe), .addr_sel_bit0(asel[0]),
    .addr_sel_bit1(asel[1]), .addr_sel_bit2(asel[2]),
    .port_pin_i(pin), .port_pin_o(po), .port_pin_oe(poe));
  iox_i2c_master mst (.sda(sda_w), .scl_low(scl_low), .sda_low(m_low));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    begin
      samples_checked++;
      if (s !== e) begin
        bad_count++;
        $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        bad_count++;
        summarize();
      end
    end
  endtask
  task automatic wait_int;
    int n;
    begin
      n = 0;
      while (int_oe !== 1'b1 && n < 20) begin
        @(negedge pclk);
        n++;
      end
      if (n >= 20) begin
        bad_count++;
        summarize();
      end
    end
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(97));
    ext = 8'($urandom);
    asel = 3'($urandom);
    dev = {DEV_ADDR_HI, asel[2], asel[1], asel[0]};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, OFF_PORT_STATE, 32'h0);
    chk("port_state", {POL_RST, DIR_RST, OUT_RST, ext}, rd);
    chk("pin_oe", 32'h0, {24'h0, poe});
    chk("int_oe", 32'h0, {31'h0, int_oe});
    $display("test reset done");
    d = 8'($urandom) | 8'h01;
    o = 8'($urandom);
    p = 8'($urandom);
    exp_r = '{8'h00, o, p, d};
    mst.wr(dev, {6'h00, PTR_OUTPUT}, o, ok);
    mst.wr(dev, {6'h00, PTR_DIRECTION}, d, ok);
    mst.wr(dev, {6'h00, PTR_POLARITY}, p, ok);
    chk("write_ack", 32'h1, {31'h0, ok});
    chk("pin_oe", {24'h0, ~d}, {24'h0, poe});
    chk("pin_o", {24'h0, o}, {24'h0, po});
    for (int i = 1; i < 4; i++) begin
      mst.rd(dev, 8'(i), g, ok);
      chk("readback", {23'h0, exp_r[i], 1'b1}, {23'h0, g, ok});
    end
    mst.wr(dev ^ 7'h01, {6'h00, PTR_OUTPUT}, ~o, ok);
    chk("foreign_ack", 32'h0, {31'h0, ok});
    chk("pin_o", {24'h0, o}, {24'h0, po});
    $display("test serial config done");
    mst.rd(dev, {6'h00, PTR_INPUT}, g, ok);
    chk("input_reg", {24'h0, (pin ^ p) & d}, {24'h0, g & d});
    repeat (4) @(posedge pclk);
    chk("int_oe", 32'h0, {31'h0, int_oe});
    ext <= ext ^ 8'h01;
    wait_int();
    chk("int_n", 32'h0, {31'h0, int_n_o});
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, OFF_IRQ_STS, 32'h0);
    chk("irq_sts", 32'h3, rd);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_STS, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    mst.rd(dev, {6'h00, PTR_INPUT}, g, ok);
    repeat (4) @(posedge pclk);
    chk("input_reg", {24'h0, (pin ^ p) & d}, {24'h0, g & d});
    chk("int_oe", 32'h0, {31'h0, int_oe});
    $display("test interrupt done");
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (12) @(posedge pclk);
    apb(1'b0, OFF_PORT_STATE, 32'h0);
    chk("port_state", {POL_RST, DIR_RST, OUT_RST, ext}, rd);
    chk("pin_oe", 32'h0, {24'h0, poe});
    mst.rd(dev, {6'h00, PTR_DIRECTION}, g, ok);
    chk("dir_reg", {23'h0, DIR_RST, 1'b1}, {23'h0, g, ok});
    $display("test soft reset done");
    summarize();
  end
endmodule
`default_nettype wire
